/* bench/pulse_sensor_model.sv */
// Sensor model: encoder phase A at a set pulse period, phase B held at the ccw_i level
`timescale 1ns/100ps
module pulse_sensor_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] period_i,
    input  wire logic       ccw_i,
    output logic            phase_a_o,
    output logic            phase_b_o
);
    logic [7:0] ticks = 8'h00;
    always @(posedge core_clk_i) begin
        if (period_i == 8'h00 || ticks >= period_i - 8'h01) begin
            ticks <= 8'h00;
        end else begin
            ticks <= ticks + 8'h01;
        end
    end
    assign phase_a_o = (period_i != 8'h00) && (ticks < (period_i >> 1));
    assign phase_b_o = ccw_i;
endmodule : pulse_sensor_model

/* bench/tb.sv */
// Testbench: register access and speed scenarios for the speed monitor
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
    import speed_monitor_pkg::*;
    localparam int GC = 50;
    logic        core_clk_i = 1'b0;
    logic        reset_i    = 1'b1;
    logic        ce_i       = 1'b1;
    logic [7:0]  address    = 8'h00;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = 32'h0000_0000;
    logic [2:0]  sel        = 3'h0;
    logic [7:0]  period     = 8'h00;
    logic        ccw        = 1'b0;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic        waitrequest, enc_a, enc_b, over_o, window_o, dir_o, err_o, cfg_invalid_o;
    int          n_mismatch = 0;
    int          compares   = 0;
    always #5 core_clk_i = ~core_clk_i;
    pulse_sensor_model u_sensor (.core_clk_i(core_clk_i), .period_i(period), .ccw_i(ccw),
        .phase_a_o(enc_a), .phase_b_o(enc_b));
    speed_threshold_window_monitor #(.GATE_CYCLES(GC)) u_dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .enc1_a_i(enc_a), .enc1_b_i(enc_b), .enc2_a_i(enc_a),
        .prox1_a_i(1'b0), .prox1_b_i(1'b0), .prox2_a_i(1'b0), .prox2_b_i(1'b0),
        .thresh_sel_bit2(sel[2]), .thresh_sel_bit1(sel[1]), .thresh_sel_bit0(sel[0]),
        .over_o(over_o), .window_o(window_o), .dir_o(dir_o), .err_o(err_o),
        .cfg_invalid_o(cfg_invalid_o));
    task automatic print_verdict();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk_i);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk_i);
            if (waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_mismatch++;
            print_verdict();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(nm, exp, rd)
    endtask : rchk
    task automatic run(input logic [7:0] p, input logic c, input logic [2:0] s);
        @(posedge core_clk_i);
        period <= p;
        ccw <= c;
        sel <= s;
        repeat (3 * GC + 4) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : run
    initial begin
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rchk("hyst", OFS_HYST, 32'h0000_0005);
        rchk("gear", OFS_GEAR, 32'h0000_000A);
        rchk("speed0", OFS_SPEED_BASE, 32'h0000_FFFF);
        rchk("unmapped", 8'h30, 32'h0000_0000);
        bus(1'b1, OFS_RES_PRI, 32'h0000_003C);
        bus(1'b1, OFS_SPEED_BASE, 32'h0000_0064);
        bus(1'b1, OFS_SPEED_BASE + 8'h04, 32'h0000_03E8);
        bus(1'b1, OFS_WIN_HIGH, 32'h0000_0190);
        bus(1'b1, OFS_WIN_LOW, 32'h0000_0064);
        bus(1'b1, OFS_CTRL, 32'h0000_6200);
        rchk("ctrl", OFS_CTRL, 32'h0000_6200);
        run(8'h00, 1'b0, 3'h0);
        `CHK("over", 1'b1, over_o)
        `CHK("window", 1'b0, window_o)
        `CHK("invalid", 1'b0, cfg_invalid_o)
        run(8'h02, 1'b1, 3'h0);
        `CHK("over", 1'b0, over_o)
        `CHK("window", 1'b1, window_o)
        `CHK("dir", 1'b1, dir_o)
        run(8'h02, 1'b1, 3'h1);
        `CHK("over", 1'b1, over_o)
        `CHK("err", 1'b0, err_o)
        rchk("status", OFS_STATUS, 32'h0000_0007);
        run(8'h0A, 1'b0, 3'h1);
        `CHK("window", 1'b0, window_o)
        `CHK("dir", 1'b0, dir_o)
        bus(1'b1, OFS_WIN_HIGH, 32'h0000_00C8);
        run(8'h02, 1'b0, 3'h1);
        `CHK("window", 1'b0, window_o)
        bus(1'b1, OFS_RES_VER, 32'h0000_003C);
        bus(1'b1, OFS_CTRL, 32'h0000_7210);
        run(8'h02, 1'b1, 3'h0);
        `CHK("err", 1'b0, err_o)
        rchk("count2", OFS_COUNT_VER, 32'h0000_0019);
        bus(1'b1, OFS_GEAR, 32'h0000_0014);
        run(8'h02, 1'b1, 3'h0);
        `CHK("err", 1'b1, err_o)
        print_verdict();
    end
endmodule : tb

/* verilog/gate_count_if.sv */
// Pulse and gate signals between the monitor and its pulse counters
`timescale 1ns/100ps
interface gate_count_if #(parameter int CW = 24);
    logic          pulse;
    logic          gate;
    logic [CW-1:0] count;
    logic          done;
    modport counter (input pulse, input gate, output count, output done);
    modport user    (output pulse, output gate, input count, input done);
endinterface : gate_count_if

/* verilog/pulse_gate_counter.sv */
// Counts rising pulse edges over one gate interval
`timescale 1ns/100ps
module pulse_gate_counter #(
    parameter int CW = 24
) (
    input  wire logic     core_clk_i,
    input  wire logic     reset_i,
    input  wire logic     ce_i,
    gate_count_if.counter port
);
    logic          prev;
    logic [CW-1:0] acc;
    wire           rise  = port.pulse & ~prev;
    wire           full  = &acc;
    wire  [CW-1:0] step  = (rise & ~full) ? {{(CW-1){1'b0}}, 1'b1} : '0;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prev       <= 1'b0;
            acc        <= '0;
            port.count <= '0;
            port.done  <= 1'b0;
        end else if (ce_i) begin
            prev      <= port.pulse;
            port.done <= port.gate;
            if (port.gate) begin
                port.count <= acc + step;
                acc        <= '0;
            end else begin
                acc <= acc + step;
            end
        end
    end
endmodule : pulse_gate_counter

/* verilog/speed_monitor_pkg.sv */
// Shared constants, register map and mode encodings of the speed threshold window monitor
package speed_monitor_pkg;

    // Clock and gate timing
    localparam int          CLK_FREQ_MHZ     = 100;
    localparam int          GATE_TIME_US     = 100000;
    localparam int          GATE_CYCLES_DEF  = GATE_TIME_US * CLK_FREQ_MHZ;
    localparam logic [31:0] GATES_PER_SEC    = 32'(1000000 / GATE_TIME_US);
    localparam int          COUNT_W          = 24;

    // Conversion figures
    localparam logic [31:0] SEC_PER_MIN      = 32'h0000_003C;
    localparam logic [31:0] MILLI_SCALE      = 32'h0000_03E8;
    localparam logic [7:0]  PCT_FULL         = 8'h64;
    localparam logic [31:0] GEAR_UNIT        = 32'h0000_000A;
    localparam logic [7:0]  MATCH_TOL_PCT    = 8'h0A;
    localparam logic [31:0] MAX_THRESH_HZ    = 32'h0001_86A0;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL         = 8'h00;
    localparam logic [7:0]  OFS_RES_PRI      = 8'h04;
    localparam logic [7:0]  OFS_RES_VER      = 8'h08;
    localparam logic [7:0]  OFS_PITCH        = 8'h0C;
    localparam logic [7:0]  OFS_GEAR         = 8'h10;
    localparam logic [7:0]  OFS_HYST         = 8'h14;
    localparam logic [7:0]  OFS_WIN_HIGH     = 8'h18;
    localparam logic [7:0]  OFS_WIN_LOW      = 8'h1C;
    localparam logic [7:0]  OFS_STATUS       = 8'h20;
    localparam logic [7:0]  OFS_COUNT_PRI    = 8'h24;
    localparam logic [7:0]  OFS_COUNT_VER    = 8'h28;
    localparam logic [7:0]  OFS_SPEED_BASE   = 8'h40;

    // Control register fields
    localparam int          CTRL_AXIS_LIN    = 0;
    localparam int          CTRL_SENS_LIN    = 1;
    localparam int          CTRL_ARR_LSB     = 2;
    localparam int          CTRL_PROX_LSB    = 5;
    localparam int          CTRL_DIR_EN      = 9;
    localparam int          CTRL_DIR_LSB     = 10;
    localparam int          CTRL_ERR_EN      = 12;
    localparam int          CTRL_WIN_EN      = 13;
    localparam int          CTRL_THR_LSB     = 14;

    // Reset values
    localparam logic [31:0] RST_CTRL         = 32'h0000_0000;
    localparam logic [15:0] RST_RES          = 16'h0001;
    localparam logic [15:0] RST_PITCH        = 16'h0001;
    localparam logic [9:0]  RST_GEAR         = 10'h00A;
    localparam logic [6:0]  RST_HYST         = 7'h05;
    localparam logic [15:0] RST_SPEED        = 16'hFFFF;

    typedef enum logic [2:0] {
        ARR_ENC, ARR_PROX, ARR_ENC_PROX, ARR_PROX_PROX, ARR_ENC_ENC
    } arrangement_t;

    typedef enum logic [3:0] {
        PROX_NONE, PROX_SRC3_NC, PROX_SRC3_NO, PROX_SNK3_NO, PROX_SNK3_NC,
        PROX_SRC4_NC_NO, PROX_SNK4_NC_NO, PROX_4_NC_NC, PROX_4_NO_NO
    } prox_type_t;

    typedef enum logic [1:0] { DIR_BOTH, DIR_CW, DIR_CCW } dir_mode_t;

endpackage : speed_monitor_pkg

/* verilog/speed_threshold_window_monitor.sv */
// Speed monitor: overspeed and window outputs from gated pulse counts
`timescale 1ns/100ps
module speed_threshold_window_monitor
    import speed_monitor_pkg::*;
#(
    parameter int GATE_CYCLES = speed_monitor_pkg::GATE_CYCLES_DEF
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        enc1_a_i,
    input  wire logic        enc1_b_i,
    input  wire logic        enc2_a_i,
    input  wire logic        prox1_a_i,
    input  wire logic        prox1_b_i,
    input  wire logic        prox2_a_i,
    input  wire logic        prox2_b_i,
    input  wire logic        thresh_sel_bit2,
    input  wire logic        thresh_sel_bit1,
    input  wire logic        thresh_sel_bit0,
    output logic             over_o,
    output logic             window_o,
    output logic             dir_o,
    output logic             err_o,
    output logic             cfg_invalid_o
);
    import speed_monitor_pkg::*;

    logic [31:0] ctrl;
    logic [15:0] res_pri;
    logic [15:0] res_ver;
    logic [15:0] pitch;
    logic [9:0]  gear;
    logic [6:0]  hyst;
    logic [15:0] win_high;
    logic [15:0] win_low;
    logic [15:0] speed_thr [8];
    logic        ack;
    logic [31:0] gate_cnt;
    logic        gate;
    logic        meas_valid;
    logic        over_trip;
    logic        above;
    logic        below;
    logic        dir_ccw;
    logic        enc_prev;
    logic        pair_fault;
    logic        rate_fault;

    gate_count_if #(.CW(COUNT_W)) c1 ();
    gate_count_if #(.CW(COUNT_W)) c2 ();

    function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        return old;
    endfunction : apply_be

    // True when measured hz lies above the threshold scaled by pct
    function automatic logic exceeds(input logic [31:0] hz, input logic [15:0] spd, input logic [7:0] pct,
                                     input logic [31:0] num, input logic [31:0] den);
        logic [63:0] lhs;
        logic [63:0] rhs;
        lhs = 64'(hz) * 64'(den) * 64'(PCT_FULL);
        rhs = 64'(spd) * 64'(num) * 64'(pct);
        return lhs > rhs;
    endfunction : exceeds

    // Configuration decode
    wire         axis_lin   = ctrl[CTRL_AXIS_LIN];
    wire         sens_lin   = axis_lin & ctrl[CTRL_SENS_LIN];
    wire [2:0]   arr        = ctrl[CTRL_ARR_LSB +: 3];
    wire [3:0]   prox_type  = ctrl[CTRL_PROX_LSB +: 4];
    wire         dir_en     = ctrl[CTRL_DIR_EN];
    wire [1:0]   dir_mode   = ctrl[CTRL_DIR_LSB +: 2];
    wire         err_en     = ctrl[CTRL_ERR_EN];
    wire         win_en     = ctrl[CTRL_WIN_EN];
    wire [2:0]   thr_m1     = ctrl[CTRL_THR_LSB +: 3];
    wire         two_sens   = (arr == ARR_ENC_PROX) || (arr == ARR_PROX_PROX) || (arr == ARR_ENC_ENC);
    wire [7:0]   pct_low    = PCT_FULL - {1'b0, hyst};
    wire [7:0]   pct_high   = PCT_FULL + {1'b0, hyst};

    wire         prox_sink  = (prox_type == PROX_SNK3_NO) || (prox_type == PROX_SNK3_NC)
                              || (prox_type == PROX_SNK4_NC_NO);
    wire         prox_nc    = (prox_type == PROX_SRC3_NC) || (prox_type == PROX_SNK3_NC)
                              || (prox_type == PROX_4_NC_NC);
    wire         prox_4w    = prox_type >= PROX_SRC4_NC_NO;
    wire         prox_compl = (prox_type == PROX_SRC4_NC_NO) || (prox_type == PROX_SNK4_NC_NO);
    wire         prox_inv   = prox_sink ^ prox_nc;
    wire         prox_on    = prox_type != PROX_NONE;
    wire         prox1_act  = prox_on & (prox1_a_i ^ prox_inv);
    wire         prox2_act  = prox_on & (prox2_a_i ^ prox_inv);
    wire         pair_bad   = prox_4w & (((prox1_a_i ^ prox1_b_i) != prox_compl)
                              | (two_sens & (arr == ARR_PROX_PROX) & ((prox2_a_i ^ prox2_b_i) != prox_compl)));

    wire         first_enc  = (arr == ARR_ENC) || (arr == ARR_ENC_PROX) || (arr == ARR_ENC_ENC);
    assign c1.pulse = first_enc ? enc1_a_i : prox1_act;
    assign c2.pulse = (arr == ARR_ENC_ENC) ? enc2_a_i : (arr == ARR_ENC_PROX) ? prox1_act : prox2_act;
    assign c1.gate  = gate;
    assign c2.gate  = gate;

    wire [31:0]  num        = sens_lin ? MILLI_SCALE
                            : axis_lin ? 32'(MILLI_SCALE * {16'h0000, res_pri}) : {16'h0000, res_pri};
    wire [31:0]  den        = sens_lin ? {16'h0000, res_pri}
                            : axis_lin ? 32'(SEC_PER_MIN * {16'h0000, pitch}) : SEC_PER_MIN;
    wire [31:0]  hz1        = 32'(64'(c1.count) * 64'(GATES_PER_SEC));

    // threshold select masked by threshold count
    wire [2:0]   sel_raw    = {thresh_sel_bit2, thresh_sel_bit1, thresh_sel_bit0};
    wire [2:0]   sel_mask   = (thr_m1 == 3'h0) ? 3'h0 : (thr_m1 == 3'h1) ? 3'h1
                            : (thr_m1 <= 3'h3) ? 3'h3 : 3'h7;
    wire [2:0]   sel        = sel_raw & sel_mask;
    wire [15:0]  sel_speed  = speed_thr[sel];

    wire         dir_active = (dir_mode == DIR_BOTH) || ((dir_mode == DIR_CW) && !dir_ccw)
                              || ((dir_mode == DIR_CCW) && dir_ccw);

    wire         thr_hi     = exceeds(hz1, sel_speed, PCT_FULL, num, den);
    wire         thr_lo     = exceeds(hz1, sel_speed, pct_low, num, den);
    wire         hi_hi      = exceeds(hz1, win_high, PCT_FULL, num, den);
    wire         hi_lo      = exceeds(hz1, win_high, pct_low, num, den);
    wire         lo_hi      = exceeds(hz1, win_low, pct_high, num, den);
    wire         lo_lo      = exceeds(hz1, win_low, PCT_FULL, num, den);

    // gear-scaled agreement of the two sensor rates
    wire [63:0]  rate_a     = sens_lin ? 64'(c2.count) * 64'(res_ver) * 64'(GEAR_UNIT)
                            : 64'(c2.count) * 64'(res_pri) * 64'(GEAR_UNIT);
    wire [63:0]  rate_b     = sens_lin ? 64'(c1.count) * 64'(res_pri) * 64'(gear)
                            : 64'(c1.count) * 64'(res_ver) * 64'(gear);
    wire [63:0]  tol_fac    = 64'(PCT_FULL + MATCH_TOL_PCT);
    wire         rate_off   = (rate_a * 64'(PCT_FULL) > rate_b * tol_fac)
                              || (rate_b * 64'(PCT_FULL) > rate_a * tol_fac);

    wire         next_invalid = (res_pri == 16'h0000) || (hyst >= 7'(PCT_FULL))
                              || (axis_lin && !sens_lin && pitch == 16'h0000)
                              || (two_sens && (gear == 10'h000 || res_ver == 16'h0000))
                              || (64'(sel_speed) * 64'(num) > 64'(MAX_THRESH_HZ) * 64'(den))
                              || (win_en && (64'(win_high) * 64'(num) > 64'(MAX_THRESH_HZ) * 64'(den)))
                              || (win_low > win_high && win_en);

    // Bus decode
    wire         req        = read | write;
    wire         hit_speed  = (address >= OFS_SPEED_BASE) && (address < OFS_SPEED_BASE + 8'h20)
                              && (address[1:0] == 2'b00);
    wire [2:0]   speed_idx  = address[4:2];
    wire [31:0]  status_w   = {27'h0, cfg_invalid_o, err_o, dir_o, window_o, over_o};
    wire [31:0]  next_rdata =
        (address == OFS_CTRL)      ? ctrl :
        (address == OFS_RES_PRI)   ? {16'h0000, res_pri} :
        (address == OFS_RES_VER)   ? {16'h0000, res_ver} :
        (address == OFS_PITCH)     ? {16'h0000, pitch} :
        (address == OFS_GEAR)      ? {22'h0, gear} :
        (address == OFS_HYST)      ? {25'h0, hyst} :
        (address == OFS_WIN_HIGH)  ? {16'h0000, win_high} :
        (address == OFS_WIN_LOW)   ? {16'h0000, win_low} :
        (address == OFS_STATUS)    ? status_w :
        (address == OFS_COUNT_PRI) ? {8'h00, c1.count} :
        (address == OFS_COUNT_VER) ? {8'h00, c2.count} :
        hit_speed                  ? {16'h0000, speed_thr[speed_idx]} : 32'h0000_0000;
    wire         wr_go      = write & ack;
    wire [31:0]  wr_val     = apply_be(next_rdata, writedata, byteenable);

    assign waitrequest = req & ~ack;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack      <= 1'b0;
            readdata <= 32'h0000_0000;
        end else if (ce_i) begin
            ack      <= req & ~ack;
            readdata <= (read & ~ack) ? next_rdata : readdata;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl     <= RST_CTRL;
            res_pri  <= RST_RES;
            res_ver  <= RST_RES;
            pitch    <= RST_PITCH;
            gear     <= RST_GEAR;
            hyst     <= RST_HYST;
            win_high <= RST_SPEED;
            win_low  <= 16'h0000;
        end else if (ce_i && wr_go) begin
            if (address == OFS_CTRL)           ctrl     <= wr_val;
            else if (address == OFS_RES_PRI)   res_pri  <= wr_val[15:0];
            else if (address == OFS_RES_VER)   res_ver  <= wr_val[15:0];
            else if (address == OFS_PITCH)     pitch    <= wr_val[15:0];
            else if (address == OFS_GEAR)      gear     <= wr_val[9:0];
            else if (address == OFS_HYST)      hyst     <= wr_val[6:0];
            else if (address == OFS_WIN_HIGH)  win_high <= wr_val[15:0];
            else if (address == OFS_WIN_LOW)   win_low  <= wr_val[15:0];
        end
    end

    generate
        for (genvar g = 0; g < 8; g++) begin : g_thr
            always_ff @(posedge core_clk_i or posedge reset_i) begin
                if (reset_i) speed_thr[g] <= RST_SPEED;
                else if (ce_i && wr_go && hit_speed && speed_idx == 3'(g)) speed_thr[g] <= wr_val[15:0];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gate_cnt <= 32'h0000_0000;
            gate     <= 1'b0;
        end else if (ce_i) begin
            gate     <= gate_cnt == 32'(GATE_CYCLES - 2);
            gate_cnt <= (gate_cnt == 32'(GATE_CYCLES - 1)) ? 32'h0000_0000 : gate_cnt + 32'h0000_0001;
        end
    end

    pulse_gate_counter #(.CW(COUNT_W)) u_cnt1 (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .port(c1));
    pulse_gate_counter #(.CW(COUNT_W)) u_cnt2 (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .port(c2));

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            enc_prev <= 1'b0;
            dir_ccw  <= 1'b0;
        end else if (ce_i) begin
            enc_prev <= enc1_a_i;
            if (first_enc && enc1_a_i && !enc_prev) dir_ccw <= enc1_b_i;
        end
    end
    assign dir_o = dir_en & dir_ccw;

    // output state at each gate result
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meas_valid <= 1'b0;
            over_trip  <= 1'b0;
            above      <= 1'b0;
            below      <= 1'b1;
            rate_fault <= 1'b0;
        end else if (ce_i && c1.done) begin
            meas_valid <= 1'b1;
            over_trip  <= dir_active & (thr_hi | (over_trip & thr_lo));
            above      <= hi_hi | (above & hi_lo);
            below      <= !lo_lo | (below & !lo_hi);
            rate_fault <= err_en & two_sens & rate_off;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pair_fault    <= 1'b0;
            cfg_invalid_o <= 1'b0;
        end else if (ce_i) begin
            pair_fault    <= err_en & (pair_bad | (pair_fault & ~gate));
            cfg_invalid_o <= next_invalid;
        end
    end
    assign err_o = rate_fault | pair_fault;

    assign over_o   = meas_valid & ~over_trip;
    assign window_o = win_en & meas_valid & ~above & ~below;

    a_over_trip_fast: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && dir_active && thr_hi |=> !over_o)
        else $error("overspeed output not false after exceed");
    a_over_true_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && !thr_lo |=> over_o)
        else $error("overspeed output not true below threshold");
    a_win_above_high: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && hi_hi |=> !window_o)
        else $error("window true above high limit");
    a_win_below_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && !lo_lo |=> !window_o)
        else $error("window true below low limit");
    a_win_inside_only: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && win_en && !hi_lo && lo_hi |=> window_o)
        else $error("window false inside range");
    a_hyst_hold_trip: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && !over_o && meas_valid && dir_active && thr_lo |=> !over_o)
        else $error("overspeed released inside hysteresis band");
    a_dir_mask_over: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && c1.done && !dir_active |=> over_o)
        else $error("threshold active in masked direction");
    a_dir_out_enable: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && first_enc && enc1_a_i && !enc_prev |=> dir_o == (dir_en && $past(enc1_b_i)))
        else $error("direction output not taken from phase on rise");
    a_gate_spacing: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && gate |-> gate_cnt == 32'(GATE_CYCLES - 1) ##1 !gate)
        else $error("gate pulses too close");

    c_over_trip:   cover property (@(posedge core_clk_i) disable iff (reset_i) $fell(over_o));
    c_window_on:   cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(window_o));
    c_rate_error:  cover property (@(posedge core_clk_i) disable iff (reset_i) $rose(err_o));
endmodule : speed_threshold_window_monitor
